// file: inc/uart_baud_cfg.svh
`ifndef UART_BAUD_CFG_SVH
`define UART_BAUD_CFG_SVH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define OFS_SERIAL_MODE   8'h00
`define OFS_POWER_CTRL    8'h04
`define OFS_TIMER_MODE    8'h08
`define OFS_T1_RELOAD     8'h0c
`define OFS_T2_CTRL       8'h10
`define OFS_T2_RELOAD_HI  8'h14
`define OFS_T2_RELOAD_LO  8'h18
`define OFS_DEDICATED     8'h1c
`define OFS_FRACTION      8'h20
`define OFS_RATE_STATUS   8'h24

// ----------------------------------------------------------------
// field positions and reset values
// ----------------------------------------------------------------
`define BIT_RATE_DOUBLER  7
`define BIT_T2_RX_SEL     5
`define BIT_T2_TX_SEL     4
`define BIT_DED_ENABLE    7
`define DED_DIV_MASK      8'h87
`define T1_AUTORELOAD     4'h2
`define RESET_BYTE        8'h00

// ----------------------------------------------------------------
// fixed dividers
// ----------------------------------------------------------------
`define MODE0_DIV         4'd12
`define MODE2_DIV_SLOW    6'd63
`define MODE2_DIV_FAST    6'd31
`define T1_OVF_SLOW       5'd31
`define T1_OVF_FAST       5'd15
`define T2_OVF_PER_BIT    4'd15
`define FRACTION_OFFSET   9'd64

`endif

// file: inc/uart_baud_pkg.sv
package uart_baud_pkg;

  typedef enum logic [1:0] {
    SER_SHIFT   = 2'h0,
    SER_UART8   = 2'h1,
    SER_FIXED9  = 2'h2,
    SER_UART9   = 2'h3
  } serial_mode_e;

  typedef logic [7:0] sfr_t;

endpackage : uart_baud_pkg

// file: logic/uart_baud_gen.sv
`timescale 1ns/1ps
`include "uart_baud_cfg.svh"

// Behaviour
// RULE1: mode 0 shift rate is core clock divided by twelve, no timer involved.
// RULE2: mode 2 rate is core clock over 64, or over 32 with doubler set.
// RULE3: modes 1 and 3 take rate from Timer 1 or Timer 2, per direction.
// RULE4: Timer 1 source gives overflow rate times two-to-doubler over thirty-two.
// RULE5: software keeps Timer 1 interrupt off; timer may run any mode.
// RULE6: Timer 1 autoreload nibble 0010 gives clock/12/(256-reload) into that formula.
// RULE7: Timer 2 source needs sixteen overflows per bit.
// RULE8: Timer 2 in rate mode counts every two core clocks.
// RULE9: Timer 2 transmit/receive select bits put that direction on Timer 2.
// RULE10: Timer 2 rate is clock over 32 times (65536 minus 16-bit reload).
// RULE11: a dedicated third timer with control and fraction registers may replace both.
// RULE12: dedicated enable bit 7 overrides doubler and Timer 2 selects.
// RULE13: control bits 2..0 hold the power-of-two prescale exponent.
// RULE14: dedicated rate is 2 x clock / (2^exponent x (fraction + 64)).
// RULE15: control bits 6..3 read zero and ignore writes.
module uart_baud_gen #(
  parameter int GAP_W = 24
) (
  // clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // ahb-lite slave
  input  wire logic        hsel,
  input  wire logic [7:0]  haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic        hready,
  input  wire logic [31:0] hwdata,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // overflow from an outside timer 1 in non-autoreload modes
  input  wire logic        timer1_overflow,
  // bit-rate enables toward the shift logic
  output logic             tx_rate_tick,
  output logic             rx_rate_tick
);

  // ----------------------------------------------------------------
  // bus slave
  // ----------------------------------------------------------------
  logic [7:0]  wr_addr_q;
  logic        wr_pend_q;
  logic [31:0] hrdata_q;
  uart_baud_pkg::serial_mode_e serial_mode_q;
  uart_baud_pkg::sfr_t power_control_reg_q;
  uart_baud_pkg::sfr_t timer_mode_reg_q;
  uart_baud_pkg::sfr_t timer1_reload_byte_q;
  uart_baud_pkg::sfr_t timer2_control_reg_q;
  uart_baud_pkg::sfr_t timer2_reload_high_q;
  uart_baud_pkg::sfr_t timer2_reload_low_q;
  uart_baud_pkg::sfr_t dedicated_rate_control_reg_q;
  uart_baud_pkg::sfr_t fraction_reload_q;

  wire        acc_valid = hsel && hready && htrans[1];
  wire        rd_req    = acc_valid && !hwrite;
  wire        wr_req    = acc_valid && hwrite;
  wire [7:0]  wbyte     = hwdata[7:0];
  wire        wr_now    = wr_pend_q;

  function automatic logic wr_hit(input logic [7:0] a, input logic [7:0] ofs,
                                  input logic pend);
    wr_hit = pend && (a == ofs);
  endfunction : wr_hit

  wire rate_doubler_bit    = power_control_reg_q[`BIT_RATE_DOUBLER];
  wire timer2_tx_sel       = timer2_control_reg_q[`BIT_T2_TX_SEL];
  wire timer2_rx_sel       = timer2_control_reg_q[`BIT_T2_RX_SEL];
  wire dedicated_rate_enable = dedicated_rate_control_reg_q[`BIT_DED_ENABLE];
  wire [2:0] prescale_exp  = dedicated_rate_control_reg_q[2:0];
  wire [15:0] t2_reload    = {timer2_reload_high_q, timer2_reload_low_q};
  wire [7:0] status_byte   = {4'h0, dedicated_rate_enable, timer2_tx_sel,
                              timer2_rx_sel, rate_doubler_bit};

  logic [31:0] rd_mux;
  always_comb
  begin
    case (haddr)
      `OFS_SERIAL_MODE:  rd_mux = {30'h0, serial_mode_q};
      `OFS_POWER_CTRL:   rd_mux = {24'h0, power_control_reg_q};
      `OFS_TIMER_MODE:   rd_mux = {24'h0, timer_mode_reg_q};
      `OFS_T1_RELOAD:    rd_mux = {24'h0, timer1_reload_byte_q};
      `OFS_T2_CTRL:      rd_mux = {24'h0, timer2_control_reg_q};
      `OFS_T2_RELOAD_HI: rd_mux = {24'h0, timer2_reload_high_q};
      `OFS_T2_RELOAD_LO: rd_mux = {24'h0, timer2_reload_low_q};
      `OFS_DEDICATED:    rd_mux = {24'h0, dedicated_rate_control_reg_q};
      `OFS_FRACTION:     rd_mux = {24'h0, fraction_reload_q};
      `OFS_RATE_STATUS:  rd_mux = {24'h0, status_byte};
      default:           rd_mux = 32'h0;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= 8'h00;
      hrdata_q  <= 32'h0;
    end
    else
    begin
      wr_pend_q <= wr_req;
      if (acc_valid)
        wr_addr_q <= haddr;
      if (rd_req)
        hrdata_q <= rd_mux;
    end
  end

  // zero-wait slave: every transfer completes in one data-phase cycle
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = hrdata_q;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      serial_mode_q                <= uart_baud_pkg::SER_SHIFT;
      power_control_reg_q          <= `RESET_BYTE;
      timer_mode_reg_q             <= `RESET_BYTE;
      timer1_reload_byte_q         <= `RESET_BYTE;
      timer2_control_reg_q         <= `RESET_BYTE;
      timer2_reload_high_q         <= `RESET_BYTE;
      timer2_reload_low_q          <= `RESET_BYTE;
      dedicated_rate_control_reg_q <= `RESET_BYTE;
      fraction_reload_q            <= `RESET_BYTE;
    end
    else
    begin
      if (wr_hit(wr_addr_q, `OFS_SERIAL_MODE, wr_now))
        serial_mode_q <= uart_baud_pkg::serial_mode_e'(wbyte[1:0]);
      if (wr_hit(wr_addr_q, `OFS_POWER_CTRL, wr_now))
        power_control_reg_q <= wbyte;
      if (wr_hit(wr_addr_q, `OFS_TIMER_MODE, wr_now))
        timer_mode_reg_q <= wbyte;
      if (wr_hit(wr_addr_q, `OFS_T1_RELOAD, wr_now))
        timer1_reload_byte_q <= wbyte;
      if (wr_hit(wr_addr_q, `OFS_T2_CTRL, wr_now))
        timer2_control_reg_q <= wbyte;
      if (wr_hit(wr_addr_q, `OFS_T2_RELOAD_HI, wr_now))
        timer2_reload_high_q <= wbyte;
      if (wr_hit(wr_addr_q, `OFS_T2_RELOAD_LO, wr_now))
        timer2_reload_low_q <= wbyte;
      if (wr_hit(wr_addr_q, `OFS_DEDICATED, wr_now))
        dedicated_rate_control_reg_q <= wbyte & `DED_DIV_MASK; // [RULE15]
      if (wr_hit(wr_addr_q, `OFS_FRACTION, wr_now))
        fraction_reload_q <= wbyte;
    end
  end

  // ----------------------------------------------------------------
  // fixed-rate dividers
  // ----------------------------------------------------------------
  logic [3:0] mc_cnt_q;
  logic [5:0] m2_cnt_q;
  wire mc_en   = (mc_cnt_q == `MODE0_DIV - 4'd1);            // [RULE1]
  wire m2_tick = rate_doubler_bit ? (m2_cnt_q[4:0] == `MODE2_DIV_FAST)
                                  : (m2_cnt_q == `MODE2_DIV_SLOW); // [RULE2]

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      mc_cnt_q <= 4'd0;
      m2_cnt_q <= 6'd0;
    end
    else
    begin
      mc_cnt_q <= mc_en ? 4'd0 : mc_cnt_q + 4'd1;
      m2_cnt_q <= m2_cnt_q + 6'd1;
    end
  end

  // ----------------------------------------------------------------
  // timer 1: autoreload counter or outside overflow
  // ----------------------------------------------------------------
  logic [7:0] t1_cnt_q;
  logic [4:0] t1_div_q;
  wire t1_autoreload = (timer_mode_reg_q[7:4] == `T1_AUTORELOAD);
  wire t1_int_ovf    = t1_autoreload && mc_en && (t1_cnt_q == 8'hff); // [RULE6]
  // any other timer 1 mode is counted outside; its interrupt stays off [RULE5]
  wire t1_ovf        = t1_autoreload ? t1_int_ovf : timer1_overflow;
  wire [4:0] t1_lim  = rate_doubler_bit ? `T1_OVF_FAST : `T1_OVF_SLOW;
  wire t1_tick       = t1_ovf && (t1_div_q == t1_lim);          // [RULE4]

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      t1_cnt_q <= 8'h00;
      t1_div_q <= 5'd0;
    end
    else
    begin
      if (t1_int_ovf)
        t1_cnt_q <= timer1_reload_byte_q;                       // [RULE6]
      else if (t1_autoreload && mc_en)
        t1_cnt_q <= t1_cnt_q + 8'h01;
      if (t1_ovf)
        t1_div_q <= (t1_div_q >= t1_lim) ? 5'd0 : t1_div_q + 5'd1;
    end
  end

  // ----------------------------------------------------------------
  // timer 2 in rate-generator mode
  // ----------------------------------------------------------------
  logic        t2_half_q;
  logic [15:0] t2_cnt_q;
  logic [3:0]  t2_div_q;
  wire t2_run  = timer2_tx_sel || timer2_rx_sel;                // [RULE9]
  wire t2_inc  = t2_run && t2_half_q;                           // [RULE8]
  wire t2_ovf  = t2_inc && (t2_cnt_q == 16'hffff);
  wire t2_tick = t2_ovf && (t2_div_q == `T2_OVF_PER_BIT);       // [RULE7]

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      t2_half_q <= 1'b0;
      t2_cnt_q  <= 16'h0000;
      t2_div_q  <= 4'd0;
    end
    else
    begin
      t2_half_q <= t2_run && !t2_half_q;
      if (t2_ovf || !t2_run) // idle timer waits at its reload, not a full 16-bit wrap away
        t2_cnt_q <= t2_reload;                                  // [RULE10]
      else if (t2_inc)
        t2_cnt_q <= t2_cnt_q + 16'h0001;
      if (t2_ovf)
        t2_div_q <= t2_div_q + 4'd1;
    end
  end

  // ----------------------------------------------------------------
  // dedicated fractional timer
  // ----------------------------------------------------------------
  // accumulates 2 per clock against 2^exp*(fraction+64): exact average rate
  logic [16:0] t3_acc_q;
  wire [16:0] t3_lim  = 17'({8'h0, fraction_reload_q} + `FRACTION_OFFSET)
                        << prescale_exp;                       // [RULE13]
  wire [16:0] t3_sum  = t3_acc_q + 17'd2;
  wire        t3_tick = dedicated_rate_enable && (t3_sum >= t3_lim); // [RULE14]
  wire        t3_cfg_wr = wr_now && (wr_addr_q == `OFS_DEDICATED || wr_addr_q == `OFS_FRACTION);

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      t3_acc_q <= 17'd0;
    else if (!dedicated_rate_enable || t3_cfg_wr) // a shrunk limit must not see an old count
      t3_acc_q <= 17'd0;
    else
      t3_acc_q <= t3_tick ? t3_sum - t3_lim : t3_sum;           // [RULE11]
  end

  // ----------------------------------------------------------------
  // source selection
  // ----------------------------------------------------------------
  wire var_mode = serial_mode_q[0];
  wire tx_var   = dedicated_rate_enable ? t3_tick
                : (timer2_tx_sel ? t2_tick : t1_tick);          // [RULE3] [RULE12]
  wire rx_var   = dedicated_rate_enable ? t3_tick
                : (timer2_rx_sel ? t2_tick : t1_tick);          // [RULE3] [RULE12]
  wire fix_tick = (serial_mode_q == uart_baud_pkg::SER_SHIFT) ? mc_en : m2_tick;
  logic tx_q;
  logic rx_q;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      tx_q <= 1'b0;
      rx_q <= 1'b0;
    end
    else
    begin
      tx_q <= var_mode ? tx_var : fix_tick;
      rx_q <= var_mode ? rx_var : fix_tick;
    end
  end

  assign tx_rate_tick = tx_q;
  assign rx_rate_tick = rx_q;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  logic [GAP_W-1:0] gap_q;
  logic             quiet_q, wr_late_q;
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      gap_q     <= '0;
      quiet_q   <= 1'b0;
      wr_late_q <= 1'b0;
    end
    else
    begin
      gap_q   <= tx_q ? '0 : gap_q + 1'b1;
      wr_late_q <= wr_pend_q;
      quiet_q   <= (wr_pend_q || wr_late_q) ? 1'b0 : (tx_q || quiet_q);
    end
  end

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  sequence s_wr_ded;
    wr_hit(wr_addr_q, `OFS_DEDICATED, wr_now);
  endsequence
  sequence s_rd_ded;
    rd_req && haddr == `OFS_DEDICATED;
  endsequence

  AST_MODE0_GAP: assert property ( // [RULE1]
    tx_q && quiet_q && serial_mode_q == uart_baud_pkg::SER_SHIFT |-> gap_q == 11)
    else $error("mode 0 period is not twelve clocks");
  AST_MODE2_GAP: assert property ( // [RULE2]
    tx_q && quiet_q && serial_mode_q == uart_baud_pkg::SER_FIXED9
    |-> gap_q == (rate_doubler_bit ? 31 : 63))
    else $error("mode 2 period wrong");
  AST_T1_SRC: assert property ( // [RULE3]
    var_mode && !dedicated_rate_enable && !timer2_tx_sel && t1_tick |=> tx_q)
    else $error("timer 1 tick not passed to transmit");
  AST_T1_DIV: assert property ( // [RULE4]
    t1_tick |-> t1_ovf && t1_div_q == (rate_doubler_bit ? 15 : 31))
    else $error("timer 1 overflow division wrong");
  AST_T1_RELOAD: assert property ( // [RULE6]
    t1_int_ovf |=> t1_cnt_q == $past(timer1_reload_byte_q))
    else $error("timer 1 did not reload");
  AST_T2_SIXTEEN: assert property ( // [RULE7]
    t2_tick |=> !t2_tick [*2] ##0 t2_div_q == 0)
    else $error("timer 2 divider not sixteen");
  AST_T2_HALF: assert property ( // [RULE8]
    t2_inc |=> !t2_inc)
    else $error("timer 2 counted on consecutive clocks");
  AST_T2_SELECT: assert property ( // [RULE9]
    var_mode && !dedicated_rate_enable && timer2_rx_sel && t2_tick |=> rx_q)
    else $error("timer 2 tick not passed to receive");
  AST_T2_RELOAD: assert property ( // [RULE10]
    t2_ovf |=> t2_cnt_q == $past(t2_reload))
    else $error("timer 2 did not reload");
  AST_DED_OVERRIDE: assert property ( // [RULE12]
    var_mode && dedicated_rate_enable |=> tx_q == rx_q)
    else $error("dedicated timer not driving both directions");
  AST_DED_GAP: assert property ( // [RULE14]
    tx_q && quiet_q && var_mode && dedicated_rate_enable && !t3_lim[0]
    |-> gap_q == GAP_W'(t3_lim[16:1] - 16'd1))
    else $error("dedicated timer period wrong");
  AST_DED_EXP: assert property ( // [RULE13]
    dedicated_rate_enable |-> t3_lim >> prescale_exp
                              == 17'(fraction_reload_q) + 17'd64)
    else $error("prescale exponent not applied");
  AST_DED_UNUSED: assert property ( // [RULE15]
    s_wr_ded ##[1:2] s_rd_ded |=> hrdata_q[6:3] == 4'h0)
    else $error("unused control bits read non-zero");
  AST_DED_ACC: assert property ( // [RULE11]
    dedicated_rate_enable |-> t3_acc_q < t3_lim)
    else $error("fraction accumulator out of range");

endmodule : uart_baud_gen

// file: verification/tb.sv
`timescale 1ns/1ps
`include "uart_baud_cfg.svh"

module tb;
  typedef struct {
    logic [7:0] mode, pwr, tmode, t1, t2c, ded, frac;
    int         etx, erx;
  } row_s;

  logic        hclk, hresetn, hsel, hwrite, timer1_overflow, ovf_en;
  logic [7:0]  haddr;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [31:0] hwdata, hrdata, rd;
  logic        hreadyout, hresp, tx_rate_tick, rx_rate_tick;
  logic [1:0]  ovf_cnt;
  int          tx_period, rx_period, tx_count, rx_count;
  int          failures, comparisons;

  // expected gaps worked out from the rate formulas, timer 1 counting once every twelve core clocks
  row_s rows [8] = '{
    '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 12, 12},
    '{8'h02, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 64, 64},
    '{8'h02, 8'h80, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 32, 32},
    '{8'h01, 8'h00, 8'h20, 8'hff, 8'h00, 8'h00, 8'h00, 32*12*1, 32*12*1},
    '{8'h03, 8'h80, 8'h20, 8'hff, 8'h00, 8'h00, 8'h00, 16*12*1, 16*12*1},
    '{8'h01, 8'h00, 8'h00, 8'h00, 8'h00, 8'h80, 8'h00, 1*64/2, 1*64/2},
    '{8'h03, 8'h80, 8'h00, 8'h00, 8'h30, 8'h82, 8'h20, 4*96/2, 4*96/2},
    '{8'h01, 8'h80, 8'h00, 8'h00, 8'h10, 8'h81, 8'h00, 2*64/2, 2*64/2}
  };

  uart_baud_gen i_dut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hready(hreadyout), .hwdata(hwdata),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .timer1_overflow(timer1_overflow), .tx_rate_tick(tx_rate_tick),
    .rx_rate_tick(rx_rate_tick)
  );

  uart_shift_model i_far (
    .hclk(hclk), .hresetn(hresetn), .tx_rate_tick(tx_rate_tick),
    .rx_rate_tick(rx_rate_tick), .tx_period(tx_period), .rx_period(rx_period),
    .tx_count(tx_count), .rx_count(rx_count)
  );

  // ----------------------------------------------------------------
  // clock, outside timer 1 overflow, watchdog
  // ----------------------------------------------------------------
  initial
  begin
    hclk = 1'b0;
    forever #12.5 hclk = ~hclk;
  end

  // outside timer 1 overflows every 4 clocks; its interrupt is never used
  always @(posedge hclk)
  begin
    ovf_cnt         <= ovf_cnt + 2'h1;
    timer1_overflow <= ovf_en && (ovf_cnt == 2'h3);
  end

  // slowest step is timer 1 climbing from 0 (about 3,000 clocks); whole run is far below this
  initial
  begin
    repeat (60000) @(posedge hclk);
    failures++;
    report_and_stop();
  end

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task report_and_stop();
    $display("checks %0d, mismatches %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : report_and_stop

  task check(input string name, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp)
    begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask : check

  task ahb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel   <= 1'b1;
    haddr  <= a;
    hwrite <= wr;
    htrans <= 2'h2;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
    check("response", 32'h0, {31'h0, hresp});
  endtask : ahb

  task check_rate(input string name, input bit rx, input int exp);
    int c0;
    c0 = rx ? rx_count : tx_count;
    while (((rx ? rx_count : tx_count) - c0) < 3) @(posedge hclk);
    check(name, exp, rx ? rx_period : tx_period);
  endtask : check_rate

  task set_all(input row_s r);
    ahb(1'b1, `OFS_POWER_CTRL, {24'h0, r.pwr});
    ahb(1'b1, `OFS_TIMER_MODE, {24'h0, r.tmode});
    ahb(1'b1, `OFS_T1_RELOAD, {24'h0, r.t1});
    ahb(1'b1, `OFS_T2_CTRL, {24'h0, r.t2c});
    ahb(1'b1, `OFS_FRACTION, {24'h0, r.frac});
    ahb(1'b1, `OFS_DEDICATED, {24'h0, r.ded});
    ahb(1'b1, `OFS_SERIAL_MODE, {24'h0, r.mode});
  endtask : set_all

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial
  begin
    hresetn = 1'b0; hsel = 1'b0; haddr = 8'h00; htrans = 2'h0; hwrite = 1'b0;
    hsize = 3'h2; hwdata = 32'h0; timer1_overflow = 1'b0; ovf_en = 1'b0;
    ovf_cnt = 2'h0; failures = 0; comparisons = 0;
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    for (int i = 0; i < 10; i++)
    begin
      ahb(1'b0, 8'(4 * i), 32'h0);
      check("reset value", 32'h0, rd);
    end
    ahb(1'b1, `OFS_DEDICATED, 32'hff);
    ahb(1'b0, `OFS_DEDICATED, 32'h0);
    check("dedicated control", 32'h87, rd);
    ahb(1'b1, `OFS_FRACTION, 32'h5a);
    ahb(1'b0, `OFS_FRACTION, 32'h0);
    check("fraction reload", 32'h5a, rd);
    ahb(1'b1, 8'h28, 32'hff);
    ahb(1'b0, 8'h28, 32'h0);
    check("unmapped", 32'h0, rd);
    // timer 2 waits at its reload while idle: load 0xfffe before any row runs it
    ahb(1'b1, `OFS_T2_RELOAD_HI, 32'hff);
    ahb(1'b1, `OFS_T2_RELOAD_LO, 32'hfe);
    foreach (rows[i])
    begin
      set_all(rows[i]);
      check_rate("tx gap", 1'b0, rows[i].etx);
      check_rate("rx gap", 1'b1, rows[i].erx);
    end
    // transmit on timer 2 reload 0xfffe, receive stays on timer 1
    set_all('{8'h01, 8'h00, 8'h20, 8'hff, 8'h10, 8'h00, 8'h00, 0, 0});
    check_rate("timer 2 tx gap", 1'b0, 32 * (65536 - 65534));
    check_rate("timer 1 rx gap", 1'b1, 32 * 12 * 1);
    // and the other way round: receive on timer 2, transmit on timer 1
    set_all('{8'h01, 8'h00, 8'h20, 8'hff, 8'h20, 8'h00, 8'h00, 0, 0});
    check_rate("timer 2 rx gap", 1'b1, 32 * (65536 - 65534));
    check_rate("timer 1 tx gap", 1'b0, 32 * 12 * 1);
    // outside timer 1 in a non-reload mode, doubler on
    ovf_en <= 1'b1;
    set_all('{8'h03, 8'h80, 8'h10, 8'h00, 8'h00, 8'h00, 8'h00, 0, 0});
    check_rate("outside timer 1 gap", 1'b0, 16 * 4);
    // second reset mid-run returns to mode 0 with cleared registers
    @(posedge hclk);
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    ahb(1'b0, `OFS_DEDICATED, 32'h0);
    check("control after reset", 32'h0, rd);
    check_rate("mode 0 after reset", 1'b0, 12);
    report_and_stop();
  end
endmodule : tb

// file: verification/uart_shift_model.sv
`timescale 1ns/1ps

// ----------------------------------------------------------------
// shift logic stand-in: spacing of bit-rate enables
// ----------------------------------------------------------------
module uart_shift_model (
  // clock and reset
  input  wire logic hclk,
  input  wire logic hresetn,
  // bit-rate enables from the generator
  input  wire logic tx_rate_tick,
  input  wire logic rx_rate_tick,
  // last spacing in core clocks, and tick counts
  output int        tx_period,
  output int        rx_period,
  output int        tx_count,
  output int        rx_count
);
  int tx_gap_q;
  int rx_gap_q;

  // a gap is only meaningful once two ticks have been seen
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      tx_gap_q  <= 0;
      rx_gap_q  <= 0;
      tx_period <= 0;
      rx_period <= 0;
      tx_count  <= 0;
      rx_count  <= 0;
    end
    else
    begin
      tx_gap_q <= tx_rate_tick ? 0 : tx_gap_q + 1;
      rx_gap_q <= rx_rate_tick ? 0 : rx_gap_q + 1;
      if (tx_rate_tick === 1'b1)
      begin
        tx_period <= tx_gap_q + 1;
        tx_count  <= tx_count + 1;
      end
      if (rx_rate_tick === 1'b1)
      begin
        rx_period <= rx_gap_q + 1;
        rx_count  <= rx_count + 1;
      end
    end
  end
endmodule : uart_shift_model
